// *** dv/core_model.sv ***
// core stand-in that offers instruction boundaries and counts vector takes
`timescale 1ns/10ps
module core_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic irq_take,
  output logic instr_boundary,
  output int takes
);
  // a stalled core is mid-instruction and must not be interrupted
  assign instr_boundary = !stall;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      takes <= 0;
    end else if (irq_take) begin
      takes <= takes + 1;
    end
  end
endmodule : core_model

// *** dv/test_irq_and_port_wake_ctrl.sv ***
// self-checking bench for the interrupt and port wake controller
`timescale 1ns/10ps
module test_irq_and_port_wake_ctrl;
  import irq_wake_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_write = 1'b0, reg_read = 1'b0, stall = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, acc = 8'h00, pflags = 8'h00;
  logic [7:0] p0 = 8'h00, p1 = 8'h00, reg_rdata, pop_acc, pop_pf;
  logic [8:0] pulses = 9'h000;
  logic [15:0] irq_vector;
  logic irq_take, instr_boundary, wake_event;
  logic [1:0] cpu_mode;
  int takes, wakes = 0, n_mismatch = 0, checked = 0;
  localparam logic [8:0] T0 = 9'h001, T1 = 9'h002, RET = 9'h004, PUSH = 9'h008;
  localparam logic [8:0] POP = 9'h010, NRM = 9'h020, SLW = 9'h040, GRN = 9'h080, SLP = 9'h100;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (wake_event === 1'b1) wakes <= wakes + 1;
  irq_and_port_wake_ctrl irq_and_port_wake_ctrl_inst (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .port0_pins(p0), .port1_pins(p1), .timer0_overflow(pulses[0]),
    .timer1_overflow(pulses[1]), .instr_boundary(instr_boundary),
    .return_from_irq_instruction(pulses[2]), .push_instruction(pulses[3]),
    .pop_instruction(pulses[4]), .accumulator(acc), .program_flags(pflags),
    .enter_normal(pulses[5]), .enter_slow(pulses[6]), .enter_green(pulses[7]),
    .enter_sleep(pulses[8]), .irq_take(irq_take), .irq_vector(irq_vector),
    .pop_accumulator(pop_acc), .pop_program_flags(pop_pf), .wake_event(wake_event),
    .cpu_mode(cpu_mode));
  core_model core_model_inst (.clk(clk), .resetn(resetn), .stall(stall), .irq_take(irq_take),
    .instr_boundary(instr_boundary), .takes(takes));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [8:0] p = 9'h000);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    pulses <= p;
    @(posedge clk);
    reg_write <= 1'b0;
    pulses <= 9'h000;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    #1 chk(16'(reg_rdata), 16'(exp));
  endtask : rd
  // waits long enough for edge detection, flag or mode update and the lagging cpu_mode
  task automatic pulse(input logic [8:0] p);
    @(posedge clk);
    pulses <= p;
    @(posedge clk);
    pulses <= 9'h000;
    repeat (4) @(posedge clk);
    #1;
  endtask : pulse
  task automatic pins(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    p0 <= a;
    p1 <= b;
    repeat (5) @(posedge clk);
    #1;
  endtask : pins
  task automatic end_of_test;
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    #20us;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    logic [1:0] e;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_EXT0_EDGE_SELECT, 8'h10);
    rd(ADDR_PORT1_WAKE_MASK, 8'h00);
    rd(ADDR_IRQ_REQUEST_FLAGS, 8'h00);
    rd(ADDR_IRQ_ENABLE_BITS, 8'h00);
    rd(ADDR_STACK_AND_GLOBAL_ENABLE, 8'h07);
    rd(8'h00, 8'h00);
    wr(ADDR_IRQ_ENABLE_BITS, 8'hff);
    rd(ADDR_IRQ_ENABLE_BITS, IRQ_BITS_MASK);
    wr(ADDR_IRQ_ENABLE_BITS, 8'h00);
    wr(ADDR_PORT1_WAKE_MASK, 8'h04);
    rd(ADDR_PORT1_WAKE_MASK, 8'h00);
    pulse(T0 | T1);
    rd(ADDR_IRQ_REQUEST_FLAGS, 8'h50);
    wr(ADDR_IRQ_REQUEST_FLAGS, 8'h00, T0);
    rd(ADDR_IRQ_REQUEST_FLAGS, 8'h10);
    // codes 01, 10, 11 and the reserved 00 in turn
    for (int c = 1; c < 5; c++) begin
      e = 2'(c);
      wr(ADDR_EXT0_EDGE_SELECT, {3'h0, e, 3'h0});
      rd(ADDR_EXT0_EDGE_SELECT, {3'h0, e, 3'h0});
      wr(ADDR_IRQ_REQUEST_FLAGS, 8'h00);
      pins(8'h03, 8'h00);
      rd(ADDR_IRQ_REQUEST_FLAGS, {7'h00, e[0]});
      wr(ADDR_IRQ_REQUEST_FLAGS, 8'h00);
      pins(8'h00, 8'h00);
      rd(ADDR_IRQ_REQUEST_FLAGS, {6'h00, 1'b1, e[1]});
    end
    chk(16'(takes), 16'h0000);
    wr(ADDR_IRQ_REQUEST_FLAGS, 8'h00);
    wr(ADDR_IRQ_ENABLE_BITS, 8'h10);
    pulse(T0);
    chk(16'(takes), 16'h0000);
    @(posedge clk);
    stall <= 1'b1;
    wr(ADDR_STACK_AND_GLOBAL_ENABLE, 8'h87);
    repeat (4) @(posedge clk);
    #1;
    chk(16'(takes), 16'h0000);
    @(posedge clk);
    stall <= 1'b0;
    for (int t = 0; t < 20 && takes == 0; t++) @(posedge clk);
    #1;
    chk(16'(takes), 16'h0001);
    chk(irq_vector, IRQ_VECTOR_ADDR);
    rd(ADDR_STACK_AND_GLOBAL_ENABLE, 8'h06);
    chk(16'(takes), 16'h0001);
    wr(ADDR_IRQ_REQUEST_FLAGS, 8'h00);
    pulse(RET);
    rd(ADDR_STACK_AND_GLOBAL_ENABLE, 8'h87);
    @(posedge clk);
    acc <= 8'ha5;
    pflags <= 8'hff;
    pulse(PUSH);
    @(posedge clk);
    acc <= 8'h00;
    pulse(POP);
    chk(16'(pop_acc), 16'h00a5);
    chk(16'(pop_pf), 16'(PROGRAM_FLAGS_SAVE_MASK));
    pulse(SLP);
    pins(8'h00, 8'h01);
    chk(16'(cpu_mode), 16'(MODE_SLEEP));
    pins(8'h00, 8'h05);
    chk(16'(wakes), 16'h0001);
    chk(16'(cpu_mode), 16'(MODE_NORMAL));
    pulse(SLW);
    pulse(GRN);
    chk(16'(cpu_mode), 16'(MODE_GREEN));
    pins(8'h20, 8'h05);
    chk(16'(cpu_mode), 16'(MODE_SLOW));
    wr(ADDR_EXT0_EDGE_SELECT, 8'h08);
    pulse(SLP);
    pins(8'h21, 8'h05);
    chk(16'(cpu_mode), 16'(MODE_NORMAL));
    chk(16'(wakes), 16'h0003);
    rd(ADDR_IRQ_REQUEST_FLAGS, 8'h01);
    pulse(SLW);
    pulse(NRM);
    chk(16'(cpu_mode), 16'(MODE_NORMAL));
    pulse(GRN);
    pulse(T0);
    chk(16'(cpu_mode), 16'(MODE_NORMAL));
    chk(16'(wakes), 16'h0004);
    chk(16'(takes), 16'h0002);
    end_of_test();
  end
endmodule : test_irq_and_port_wake_ctrl

// *** pkg/irq_wake_pkg.sv ***
// constants for the interrupt and port wake controller
package irq_wake_pkg;
  localparam logic [7:0] ADDR_EXT0_EDGE_SELECT = 8'hbf;
  localparam logic [7:0] ADDR_PORT1_WAKE_MASK = 8'hc0;
  localparam logic [7:0] ADDR_IRQ_REQUEST_FLAGS = 8'hc8;
  localparam logic [7:0] ADDR_IRQ_ENABLE_BITS = 8'hc9;
  localparam logic [7:0] ADDR_STACK_AND_GLOBAL_ENABLE = 8'hdf;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_EXT1 = 1;
  localparam int BIT_TIMER0 = 4;
  localparam int BIT_TIMER1 = 6;
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int EDGE_FIELD_LSB = 3;
  localparam logic [7:0] IRQ_BITS_MASK = 8'h53;
  localparam logic [1:0] EDGE_FIELD_RESET = 2'h2;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [7:0] PORT1_WAKE_MASK_RESET = 8'h00;
  localparam logic [2:0] STACK_LEVEL_RESET = 3'h7;
  localparam logic [15:0] IRQ_VECTOR_ADDR = 16'h0008;
  localparam logic [7:0] PROGRAM_FLAGS_SAVE_MASK = 8'h3f;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SLOW = 2'b01,
    MODE_GREEN = 2'b10,
    MODE_SLEEP = 2'b11
  } cpu_mode_e;
endpackage : irq_wake_pkg

// *** rtl/edge_detect.sv ***
// per-pin edge detector on synchronous input pins
`timescale 1ns/10ps
module edge_detect #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] last;
  logic primed;
  // edges are masked until the history holds a real sample, so no idle level
  // at reset release can look like an edge, whichever way a pin rests
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          last[g] <= 1'b0;
        end else begin
          last[g] <= pins[g];
        end
      end
      assign rise[g] = primed & pins[g] & ~last[g];
      assign fall[g] = primed & ~pins[g] & last[g];
    end
  endgenerate
endmodule : edge_detect

// *** rtl/irq_and_port_wake_ctrl.sv ***
// interrupt controller with port wake mask and push/pop buffer
// Behaviour
// - any port 0 change wakes; port 1 pins wake only if masked in
// - port 1 wake mask is write-only, resets to zero, bit n per pin
// - port wake works in sleep and green mode and resumes running
// - external interrupt event wakes from sleep to normal mode
// - entering service clears global enable
// - return-from-interrupt sets global enable
// - taking interrupt pushes stack one level and jumps to address 8
// - no vectoring while global enable is zero
// - enable register bits 0,1,4,6, read/write, reset zero
// - flags share enable bit positions; hardware sets, software clears
// - external source 0 event sets its flag regardless of enable
// - vector only when enable and flag of a source are both one
// - external source 1 sets flag regardless of enable, same service rule
// - external source 1 detects falling edges only
// - source 0 edge field bits 4:3, reset 10: 01 rise, 10 fall, 11 both
// - one-level push/pop buffer of accumulator and flags without status bits
// - timer overflows set their flags regardless of enable
// - green mode wake resumes the previous normal or slow mode
`timescale 1ns/10ps
module irq_and_port_wake_ctrl
  import irq_wake_pkg::*;
#(
  parameter int PORT_WIDTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [PORT_WIDTH-1:0] port0_pins,
  input wire logic [PORT_WIDTH-1:0] port1_pins,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instruction,
  input wire logic push_instruction,
  input wire logic pop_instruction,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] program_flags,
  input wire logic enter_slow,
  input wire logic enter_normal,
  input wire logic enter_green,
  input wire logic enter_sleep,
  output logic irq_take,
  output logic [15:0] irq_vector,
  output logic [7:0] pop_accumulator,
  output logic [7:0] pop_program_flags,
  output logic wake_event,
  output logic [1:0] cpu_mode
);
  logic [1:0] ext0_edge_field;
  logic [PORT_WIDTH-1:0] port1_wake_mask;
  logic [7:0] irq_request_flags;
  logic [7:0] irq_enable_bits;
  logic global_irq_enable;
  logic [2:0] stack_level_bits;
  logic [7:0] save_accumulator;
  logic [7:0] save_program_flags;
  cpu_mode_e mode;
  cpu_mode_e resume_mode;
  logic [PORT_WIDTH-1:0] p0_rise, p0_fall, p1_rise, p1_fall;

  edge_detect #(.WIDTH(2*PORT_WIDTH)) u_edges (
    .clk(clk),
    .resetn(resetn),
    .pins({port1_pins, port0_pins}),
    .rise({p1_rise, p0_rise}),
    .fall({p1_fall, p0_fall})
  );

  wire wr_edge = reg_write && reg_addr == ADDR_EXT0_EDGE_SELECT;
  wire wr_wake = reg_write && reg_addr == ADDR_PORT1_WAKE_MASK;
  wire wr_flags = reg_write && reg_addr == ADDR_IRQ_REQUEST_FLAGS;
  wire wr_enable = reg_write && reg_addr == ADDR_IRQ_ENABLE_BITS;
  wire wr_stack = reg_write && reg_addr == ADDR_STACK_AND_GLOBAL_ENABLE;

  // reserved code 00 detects nothing
  wire ext0_event = (ext0_edge_field[0] & p0_rise[0]) |
                    (ext0_edge_field[1] & p0_fall[0]);
  wire ext1_event = p0_fall[1];
  wire [7:0] hw_set = ((8'h01 & {8{ext0_event}})
                    | (8'h02 & {8{ext1_event}})
                    | (8'h10 & {8{timer0_overflow}})
                    | (8'h40 & {8{timer1_overflow}})) & IRQ_BITS_MASK;
  wire [7:0] pending = irq_request_flags & irq_enable_bits;
  wire running = mode == MODE_NORMAL || mode == MODE_SLOW;
  wire next_irq_take = running && instr_boundary && global_irq_enable
                     && |pending && !return_from_irq_instruction;
  wire [PORT_WIDTH-1:0] port_change = p0_rise | p0_fall;
  wire port_wake = |port_change | |((p1_rise | p1_fall) & port1_wake_mask);
  wire sleeping = mode == MODE_GREEN || mode == MODE_SLEEP;
  wire next_wake = sleeping && (port_wake || ext0_event || ext1_event
                 || (mode == MODE_GREEN && timer0_overflow));

  // flags: the set term is or-ed after the clear so an event is never lost
  wire [7:0] next_flags = ((wr_flags ? reg_wdata : irq_request_flags) | hw_set)
                        & IRQ_BITS_MASK;
  wire [7:0] rd_value =
      reg_addr == ADDR_EXT0_EDGE_SELECT ? 8'({ext0_edge_field, 3'h0}) :
      reg_addr == ADDR_IRQ_REQUEST_FLAGS ? irq_request_flags :
      reg_addr == ADDR_IRQ_ENABLE_BITS ? irq_enable_bits :
      reg_addr == ADDR_STACK_AND_GLOBAL_ENABLE ?
        {global_irq_enable, 4'h0, stack_level_bits} : 8'h00; // wake mask reads zero

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_request_flags <= 8'h00;
    end else begin
      irq_request_flags <= next_flags;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext0_edge_field <= EDGE_FIELD_RESET;
      port1_wake_mask <= PORT1_WAKE_MASK_RESET;
      irq_enable_bits <= 8'h00;
    end else begin
      if (wr_edge) ext0_edge_field <= reg_wdata[EDGE_FIELD_LSB +: 2];
      if (wr_wake) port1_wake_mask <= reg_wdata[PORT_WIDTH-1:0];
      if (wr_enable) irq_enable_bits <= reg_wdata & IRQ_BITS_MASK;
    end
  end

  // hardware vectoring has priority over a software write in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      global_irq_enable <= 1'b0;
      stack_level_bits <= STACK_LEVEL_RESET;
    end else if (next_irq_take) begin
      global_irq_enable <= 1'b0;
      stack_level_bits <= stack_level_bits - 3'h1;
    end else if (return_from_irq_instruction) begin
      global_irq_enable <= 1'b1;
      stack_level_bits <= stack_level_bits + 3'h1;
    end else if (wr_stack) begin
      global_irq_enable <= reg_wdata[BIT_GLOBAL_IRQ_ENABLE];
      stack_level_bits <= reg_wdata[2:0];
    end
  end

  // single level: a second push overwrites the first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      save_accumulator <= 8'h00;
      save_program_flags <= 8'h00;
    end else if (push_instruction) begin
      save_accumulator <= accumulator;
      save_program_flags <= program_flags & PROGRAM_FLAGS_SAVE_MASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode <= MODE_NORMAL;
      resume_mode <= MODE_NORMAL;
    end else begin
      unique case (mode)
        MODE_NORMAL, MODE_SLOW: begin
          if (enter_sleep) begin
            mode <= MODE_SLEEP;
          end else if (enter_green) begin
            mode <= MODE_GREEN;
            resume_mode <= mode;
          end else if (enter_slow) begin
            mode <= MODE_SLOW;
          end else if (enter_normal) begin
            mode <= MODE_NORMAL;
          end
        end
        MODE_GREEN: begin
          if (next_wake) mode <= resume_mode;
        end
        MODE_SLEEP: begin
          if (next_wake) mode <= MODE_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      irq_take <= 1'b0;
      irq_vector <= 16'h0000;
      pop_accumulator <= 8'h00;
      pop_program_flags <= 8'h00;
      wake_event <= 1'b0;
      cpu_mode <= MODE_NORMAL;
    end else begin
      if (reg_read) reg_rdata <= rd_value;
      irq_take <= next_irq_take;
      if (next_irq_take) irq_vector <= IRQ_VECTOR_ADDR;
      if (pop_instruction) begin
        pop_accumulator <= save_accumulator;
        pop_program_flags <= save_program_flags;
      end
      wake_event <= next_wake;
      cpu_mode <= mode;
    end
  end

  property p_flag_set_wins;
    @(posedge clk) disable iff (!resetn)
      (timer0_overflow && wr_flags && !reg_wdata[BIT_TIMER0]) |=> irq_request_flags[BIT_TIMER0];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("timer0 flag lost");

  property p_take_clears_gie;
    @(posedge clk) disable iff (!resetn)
      next_irq_take |=> !global_irq_enable && irq_take && irq_vector == 16'h0008;
  endproperty
  a_take_clears_gie: assert property (p_take_clears_gie) else $error("vector entry wrong");

  property p_return_from_irq_instruction_sets_gie;
    @(posedge clk) disable iff (!resetn)
      (return_from_irq_instruction && !next_irq_take) |=> global_irq_enable;
  endproperty
  a_return_from_irq_instruction_sets_gie: assert property (p_return_from_irq_instruction_sets_gie) else $error("gie not set");

  property p_stack_push;
    @(posedge clk) disable iff (!resetn)
      next_irq_take |=> stack_level_bits == $past(stack_level_bits) - 3'h1;
  endproperty
  a_stack_push: assert property (p_stack_push) else $error("stack not pushed");

  property p_no_take_without_gie;
    @(posedge clk) disable iff (!resetn)
      !global_irq_enable |=> !irq_take;
  endproperty
  a_no_take_without_gie: assert property (p_no_take_without_gie) else $error("take w/o gie");

  property p_take_needs_pending;
    @(posedge clk) disable iff (!resetn)
      (pending == 8'h00) |=> !irq_take;
  endproperty
  a_take_needs_pending: assert property (p_take_needs_pending) else $error("take w/o pend");

  property p_ext1_fall;
    @(posedge clk) disable iff (!resetn)
      (!port0_pins[1] && $past(port0_pins[1]) && $past(resetn))
        |=> irq_request_flags[BIT_EXT1];
  endproperty
  a_ext1_fall: assert property (p_ext1_fall) else $error("ext1 fall missed");

  property p_ext0_rise_only;
    @(posedge clk) disable iff (!resetn)
      (ext0_edge_field == EDGE_RISING && p0_fall[0] && !wr_flags
       && !irq_request_flags[BIT_EXT0]) |=> !irq_request_flags[BIT_EXT0];
  endproperty
  a_ext0_rise_only: assert property (p_ext0_rise_only) else $error("ext0 wrong edge");

  property p_sleep_wakes_normal;
    @(posedge clk) disable iff (!resetn)
      (mode == MODE_SLEEP && |port_change) |=> mode == MODE_NORMAL ##1 wake_event == 1'b0;
  endproperty
  a_sleep_wakes_normal: assert property (p_sleep_wakes_normal) else $error("no wake");

  property p_green_resume;
    @(posedge clk) disable iff (!resetn)
      (mode == MODE_GREEN && next_wake) |=> mode == resume_mode;
  endproperty
  a_green_resume: assert property (p_green_resume) else $error("bad resume");

  // resume_mode only ever holds normal or slow, so green must be left at once
  property p_green_timer_wake;
    @(posedge clk) disable iff (!resetn)
      (mode == MODE_GREEN && timer0_overflow) |=> wake_event && mode != MODE_GREEN;
  endproperty
  a_green_timer_wake: assert property (p_green_timer_wake) else $error("no timer wake");
endmodule : irq_and_port_wake_ctrl
